/* shared/path_cfg_pkg.sv */
// Constants and types shared by the signal-path configuration block
package path_cfg_pkg;
  // Four-level strap encoding
  typedef enum logic [1:0] {
    LVL_LOW = 2'h0,
    LVL_RES = 2'h1,
    LVL_FLOAT = 2'h2,
    LVL_HIGH = 2'h3
  } strap_level_t;
  // Detected rate from the reclocker
  typedef enum logic [1:0] {
    RATE_NONE = 2'h0,
    RATE_SD = 2'h1,
    RATE_HD = 2'h2,
    RATE_3G = 2'h3
  } data_rate_t;
  // Line amplitude selection
  typedef enum logic [1:0] {
    AMP_NOMINAL = 2'h0,
    AMP_PLUS5 = 2'h1,
    AMP_PLUS10 = 2'h2,
    AMP_MINUS5 = 2'h3
  } amp_sel_t;
  // Eye monitor sweep states, Gray along the usual path
  typedef enum logic [1:0] {
    EYE_IDLE = 2'h0,
    EYE_SWEEP = 2'h1,
    EYE_REDUCE = 2'h3,
    EYE_DONE = 2'h2
  } eye_state_t;
  localparam int EYE_STEPS = 64;
  localparam int EYE_IDX_W = 6;
  localparam int HIT_W = 16;
  localparam int EYE_SPAN_MV = 400;
  localparam int SPAN_W = 9;
  localparam logic [SPAN_W-1:0] SPAN_RESET = 9'h190;
  localparam logic [EYE_IDX_W-1:0] MID_INDEX = 6'h20;
  localparam logic [7:0] PREEMPH_RESET = 8'h00;
  localparam logic [7:0] NOM_AMP_RESET = 8'h80;
endpackage : path_cfg_pkg

/* verification/eye_sampler_model.sv */
// Sampler model that reports hits outside a fixed rectangular eye
`timescale 1ns/10ps
module eye_sampler_model #(
  parameter int PH_LO = 16,
  parameter int PH_HI = 48,
  parameter int V_LO = 20,
  parameter int V_HI = 44
) (
  // Clock and grid point
  input wire logic clk_in,
  input wire logic [5:0] phase_in,
  input wire logic [5:0] volt_in,
  // Sampler result
  output logic hit_out
);
  initial hit_out = 1'b0;
  // Off the sampling edge so each hit lines up with its grid point
  always @(negedge clk_in) begin
    hit_out <= (phase_in < PH_LO) || (phase_in >= PH_HI) || (volt_in < V_LO) || (volt_in >= V_HI);
  end
endmodule : eye_sampler_model

/* verification/path_cfg_eye_tb_top.sv */
// Self-checking bench for the path configuration and eye monitor block
`timescale 1ns/10ps
module path_cfg_eye_tb_top;
  import path_cfg_pkg::*;
  localparam int PH_LO = 16;
  localparam int PH_HI = 48;
  localparam int V_LO = 20;
  localparam int V_HI = 44;
  logic clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic [1:0] direction_mode_pin_in = 2'h0, bypass_pin_in = 2'h2, line_amplitude_pin_in = 2'h2;
  data_rate_t detected_rate_in = RATE_3G;
  logic bypass_ovr_en_in = 1'b0, eq_bypass_ovr_in = 1'b0, reclock_bypass_ovr_in = 1'b0, amp_ovr_en_in = 1'b0;
  amp_sel_t amp_ovr_in = AMP_NOMINAL;
  logic [7:0] nominal_amp_in = 8'h80, preemph_amount_in = 8'h00;
  logic preemph_manual_in = 1'b0, edge_slow_manual_in = 1'b0, invert_bidir_in = 1'b0, invert_second_in = 1'b0;
  logic eye_start_in = 1'b0, eye_hit_in;
  logic [8:0] eye_span_mv_in = 9'h190;
  logic [11:0] hit_rd_addr_in = 12'h000;
  logic driver_mode_out, eq_bypass_out, reclock_bypass_out, manual_adapt_setting_out;
  logic line_bidir_port_drive_out, line_second_output_drive_out, preemph_en_out, edge_slow_out;
  logic invert_bidir_out, invert_second_out, eye_busy_out, eye_valid_out;
  amp_sel_t amp_sel_out;
  logic [7:0] nominal_amp_out, preemph_amount_out;
  logic [5:0] eye_phase_out, eye_volt_out;
  logic [8:0] eye_volt_mv_out;
  logic [6:0] horizontal_eye_width_out, vertical_eye_height_out;
  logic [15:0] hit_rd_data_out;
  int err_total = 0;
  int checks = 0;

  path_cfg_eye dut_u (
    .clk_in(clk_in), .srst_in(srst_in), .direction_mode_pin_in(direction_mode_pin_in),
    .bypass_pin_in(bypass_pin_in), .line_amplitude_pin_in(line_amplitude_pin_in),
    .detected_rate_in(detected_rate_in), .bypass_ovr_en_in(bypass_ovr_en_in),
    .eq_bypass_ovr_in(eq_bypass_ovr_in), .reclock_bypass_ovr_in(reclock_bypass_ovr_in),
    .amp_ovr_en_in(amp_ovr_en_in), .amp_ovr_in(amp_ovr_in), .nominal_amp_in(nominal_amp_in),
    .preemph_manual_in(preemph_manual_in), .preemph_amount_in(preemph_amount_in),
    .edge_slow_manual_in(edge_slow_manual_in), .invert_bidir_in(invert_bidir_in),
    .invert_second_in(invert_second_in), .eye_start_in(eye_start_in), .eye_span_mv_in(eye_span_mv_in),
    .eye_hit_in(eye_hit_in), .driver_mode_out(driver_mode_out), .eq_bypass_out(eq_bypass_out),
    .reclock_bypass_out(reclock_bypass_out), .manual_adapt_setting_out(manual_adapt_setting_out),
    .line_bidir_port_drive_out(line_bidir_port_drive_out),
    .line_second_output_drive_out(line_second_output_drive_out), .amp_sel_out(amp_sel_out),
    .nominal_amp_out(nominal_amp_out), .preemph_en_out(preemph_en_out), .preemph_amount_out(preemph_amount_out),
    .edge_slow_out(edge_slow_out), .invert_bidir_out(invert_bidir_out), .invert_second_out(invert_second_out),
    .eye_phase_out(eye_phase_out), .eye_volt_out(eye_volt_out), .eye_volt_mv_out(eye_volt_mv_out),
    .eye_busy_out(eye_busy_out), .eye_valid_out(eye_valid_out),
    .horizontal_eye_width_out(horizontal_eye_width_out), .vertical_eye_height_out(vertical_eye_height_out),
    .hit_rd_addr_in(hit_rd_addr_in), .hit_rd_data_out(hit_rd_data_out));
  eye_sampler_model #(.PH_LO(PH_LO), .PH_HI(PH_HI), .V_LO(V_LO), .V_HI(V_HI)) sampler_u (
    .clk_in(clk_in), .phase_in(eye_phase_out), .volt_in(eye_volt_out), .hit_out(eye_hit_in));

  always #25 clk_in = ~clk_in;

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_in);
  endtask : cyc

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : complete_run

  task automatic t_reset();
    chk(line_second_output_drive_out, 1'b1);
    chk(nominal_amp_out, 8'h80);
    chk(eye_volt_mv_out, 9'h190);
    chk(driver_mode_out, 1'b0);
    chk(eye_valid_out, 1'b0);
    $display("test reset done");
  endtask : t_reset

  task automatic t_bypass();
    for (int i = 0; i < 8; i++) begin
      direction_mode_pin_in = (i < 4) ? 2'h0 : 2'h3;
      bypass_pin_in = i[1:0];
      cyc(4);
      chk(driver_mode_out, i >= 4);
      chk(line_bidir_port_drive_out, i >= 4);
      chk(line_second_output_drive_out, 1'b1);
      chk(reclock_bypass_out, i[1:0] < 2);
      if (i < 4) chk(eq_bypass_out, i[0]);
      else chk({eq_bypass_out, manual_adapt_setting_out}, i[1:0] < 2);
    end
    direction_mode_pin_in = 2'h0;
    bypass_pin_in = 2'h2;
    bypass_ovr_en_in = 1'b1;
    for (int j = 0; j < 2; j++) begin
      eq_bypass_ovr_in = !j[0];
      reclock_bypass_ovr_in = j[0];
      cyc(4);
      chk({eq_bypass_out, reclock_bypass_out}, j[0] ? 2'h1 : 2'h2);
    end
    bypass_ovr_en_in = 1'b0;
    $display("test bypass done");
  endtask : t_bypass

  task automatic t_amp();
    amp_sel_t amp_of[4] = '{AMP_MINUS5, AMP_PLUS10, AMP_NOMINAL, AMP_PLUS5};
    for (int i = 0; i < 4; i++) begin
      line_amplitude_pin_in = i[1:0];
      cyc(4);
      chk(amp_sel_out, amp_of[i]);
    end
    amp_ovr_en_in = 1'b1;
    for (int k = 0; k < 4; k++) begin
      amp_ovr_in = amp_sel_t'(k[1:0]);
      cyc(2);
      chk(amp_sel_out, k[1:0]);
    end
    nominal_amp_in = 8'h9C;
    cyc(2);
    chk(nominal_amp_out, 8'h9C);
    amp_ovr_en_in = 1'b0;
    $display("test amplitude done");
  endtask : t_amp

  task automatic t_drive();
    direction_mode_pin_in = 2'h3;
    for (int r = 1; r < 4; r++) begin
      detected_rate_in = data_rate_t'(r[1:0]);
      cyc(4);
      chk(edge_slow_out, r == 1);
      chk(preemph_en_out, 1'b0);
    end
    preemph_manual_in = 1'b1;
    preemph_amount_in = 8'h5A;
    cyc(2);
    chk(preemph_en_out, 1'b1);
    chk(preemph_amount_out, 8'h5A);
    // Reclocker bypassed, so the host sets the edge rate
    bypass_pin_in = 2'h0;
    for (int m = 0; m < 2; m++) begin
      detected_rate_in = m ? RATE_HD : RATE_SD;
      edge_slow_manual_in = m[0];
      cyc(4);
      chk(edge_slow_out, m[0]);
    end
    for (int m = 0; m < 4; m++) begin
      invert_bidir_in = m[0];
      invert_second_in = m[1];
      cyc(2);
      chk({invert_second_out, invert_bidir_out}, m[1:0]);
    end
    bypass_pin_in = 2'h2;
    detected_rate_in = RATE_HD;
    $display("test driver done");
  endtask : t_drive

  task automatic start_eye();
    eye_start_in = 1'b1;
    cyc(1);
    eye_start_in = 1'b0;
    cyc(2);
  endtask : start_eye

  task automatic t_eye();
    int n;
    logic [11:0] addr[3] = '{12'h80A, 12'h814, 12'h160};
    start_eye();
    chk({eye_busy_out, eye_valid_out}, 2'h0);
    detected_rate_in = RATE_3G;
    eye_span_mv_in = 9'h1F4;
    start_eye();
    chk(eye_busy_out, 1'b1);
    chk(eye_volt_mv_out, 9'h190);
    n = 0;
    while (eye_valid_out !== 1'b1 && n < 5000) begin
      cyc(1);
      n++;
    end
    chk(n >= 4096 && n < 4200, 1'b1);
    chk(horizontal_eye_width_out, PH_HI - PH_LO);
    chk(vertical_eye_height_out, V_HI - V_LO);
    for (int a = 0; a < 3; a++) begin
      hit_rd_addr_in = addr[a];
      cyc(2);
      chk(hit_rd_data_out, a != 1);
    end
    detected_rate_in = RATE_HD;
    cyc(1);
    chk(eye_valid_out, 1'b0);
    detected_rate_in = RATE_3G;
    eye_span_mv_in = 9'h0C8;
    start_eye();
    chk(eye_volt_mv_out, 9'h0C8);
    cyc(100);
    detected_rate_in = RATE_SD;
    cyc(2);
    chk({eye_busy_out, eye_valid_out}, 2'h0);
    $display("test eye done");
  endtask : t_eye

  initial begin
    #(40000 * 50);
    err_total++;
    complete_run();
  end

  initial begin
    cyc(20);
    t_reset();
    srst_in = 1'b0;
    t_bypass();
    t_amp();
    t_drive();
    t_eye();
    complete_run();
  end
endmodule : path_cfg_eye_tb_top

/* verilog/path_cfg_eye.sv */
// Strap decoding, overrides, driver settings and eye-opening monitor
//
// Functional notes
// R1 - Eye monitor runs only at top rate; code finishes a reduce pass already started at any rate
// R2 - 64 phase by 64 voltage capture grid
// R3 - Hit count kept per grid point; code stores one 0/1 hit sample per point
// R4 - Eye width and height readable
// R5 - Equalizer mode bypass pin decode
// R6 - Driver mode bypass pin decode, manual adapt
// R7 - Override bits replace bypass decode
// R8 - Driver mode makes bidir port output
// R9 - Amplitude pin decode, four levels
// R10 - Register overrides amplitude and nominal
// R11 - Driver mode pre-emphasis off by default
// R12 - Manual pre-emphasis enable control
// R13 - Edge rate follows detected rate
// R14 - Host sets edge rate when bypassed
// R15 - Independent polarity on both line outputs
// R16 - Mode pin low equalizer, high driver
`timescale 1ns/10ps
module path_cfg_eye (
  // Clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // Strap pins, asynchronous
  input wire logic [1:0] direction_mode_pin_in,
  input wire logic [1:0] bypass_pin_in,
  input wire logic [1:0] line_amplitude_pin_in,
  // Reclocker status, same clock
  input wire path_cfg_pkg::data_rate_t detected_rate_in,
  // Override controls
  input wire logic bypass_ovr_en_in,
  input wire logic eq_bypass_ovr_in,
  input wire logic reclock_bypass_ovr_in,
  input wire logic amp_ovr_en_in,
  input wire path_cfg_pkg::amp_sel_t amp_ovr_in,
  input wire logic [7:0] nominal_amp_in,
  input wire logic preemph_manual_in,
  input wire logic [7:0] preemph_amount_in,
  input wire logic edge_slow_manual_in,
  input wire logic invert_bidir_in,
  input wire logic invert_second_in,
  // Eye monitor control and sampler
  input wire logic eye_start_in,
  input wire logic [path_cfg_pkg::SPAN_W-1:0] eye_span_mv_in,
  input wire logic eye_hit_in,
  // Path settings
  output logic driver_mode_out,
  output logic eq_bypass_out,
  output logic reclock_bypass_out,
  output logic manual_adapt_setting_out,
  output logic line_bidir_port_drive_out,
  output logic line_second_output_drive_out,
  output path_cfg_pkg::amp_sel_t amp_sel_out,
  output logic [7:0] nominal_amp_out,
  output logic preemph_en_out,
  output logic [7:0] preemph_amount_out,
  output logic edge_slow_out,
  output logic invert_bidir_out,
  output logic invert_second_out,
  // Eye monitor results
  output logic [5:0] eye_phase_out,
  output logic [5:0] eye_volt_out,
  output logic [8:0] eye_volt_mv_out,
  output logic eye_busy_out,
  output logic eye_valid_out,
  output logic [6:0] horizontal_eye_width_out,
  output logic [6:0] vertical_eye_height_out,
  input wire logic [11:0] hit_rd_addr_in,
  output logic [15:0] hit_rd_data_out
);
  import path_cfg_pkg::*;

  logic [1:0] mode_s1, mode_s2, byp_s1, byp_s2, amp_s1, amp_s2;
  logic drv;
  strap_level_t byp_lvl;
  eye_state_t eye_state;
  logic [EYE_IDX_W-1:0] ph, vo;
  logic [HIT_W-1:0] hits [0:EYE_STEPS*EYE_STEPS-1];
  logic [6:0] width_cnt, height_cnt;
  logic top_rate;

  function automatic logic [11:0] grid_addr(input logic [5:0] v, input logic [5:0] p);
    grid_addr = {v, p};
  endfunction : grid_addr

  // Requested span limited to the largest supported swing
  function automatic logic [SPAN_W-1:0] clamp_span(input logic [SPAN_W-1:0] req);
    clamp_span = (req > SPAN_RESET) ? SPAN_RESET : req;
  endfunction : clamp_span

  // Two-stage synchronisers on strap pins
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      mode_s1 <= 2'h0;
      mode_s2 <= 2'h0;
      byp_s1 <= 2'h2;
      byp_s2 <= 2'h2;
      amp_s1 <= 2'h2;
      amp_s2 <= 2'h2;
    end else begin
      mode_s1 <= direction_mode_pin_in;
      mode_s2 <= mode_s1;
      byp_s1 <= bypass_pin_in;
      byp_s2 <= byp_s1;
      amp_s1 <= line_amplitude_pin_in;
      amp_s2 <= amp_s1;
    end
  end

  // R16 mode pin decode
  assign drv = (mode_s2 == LVL_HIGH);
  assign byp_lvl = strap_level_t'(byp_s2);
  assign top_rate = (detected_rate_in == RATE_3G);

  // Path configuration registers
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      driver_mode_out <= 1'b0;
      eq_bypass_out <= 1'b0;
      reclock_bypass_out <= 1'b0;
      manual_adapt_setting_out <= 1'b0;
      line_bidir_port_drive_out <= 1'b0;
      line_second_output_drive_out <= 1'b1;
    end else begin
      driver_mode_out <= drv;
      // R8 line outputs drive
      line_bidir_port_drive_out <= drv;
      line_second_output_drive_out <= 1'b1;
      if (bypass_ovr_en_in) begin
        // R7 override replaces decode
        eq_bypass_out <= eq_bypass_ovr_in;
        reclock_bypass_out <= reclock_bypass_ovr_in;
        manual_adapt_setting_out <= drv && reclock_bypass_ovr_in;
      end else if (drv) begin
        // R6 driver mode decode
        eq_bypass_out <= 1'b0;
        reclock_bypass_out <= (byp_lvl == LVL_RES) || (byp_lvl == LVL_LOW);
        manual_adapt_setting_out <= (byp_lvl == LVL_RES) || (byp_lvl == LVL_LOW);
      end else begin
        // R5 equalizer mode decode
        eq_bypass_out <= (byp_lvl == LVL_HIGH) || (byp_lvl == LVL_RES);
        reclock_bypass_out <= (byp_lvl == LVL_RES) || (byp_lvl == LVL_LOW);
        manual_adapt_setting_out <= 1'b0;
      end
    end
  end

  // Driver amplitude, emphasis, edge, polarity
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      amp_sel_out <= AMP_NOMINAL;
      nominal_amp_out <= NOM_AMP_RESET;
      preemph_en_out <= 1'b0;
      preemph_amount_out <= PREEMPH_RESET;
      edge_slow_out <= 1'b0;
      invert_bidir_out <= 1'b0;
      invert_second_out <= 1'b0;
    end else begin
      // R10 amplitude override and nominal
      nominal_amp_out <= nominal_amp_in;
      if (amp_ovr_en_in) begin
        amp_sel_out <= amp_ovr_in;
      end else begin
        // R9 amplitude pin decode
        case (strap_level_t'(amp_s2))
          LVL_FLOAT: amp_sel_out <= AMP_NOMINAL;
          LVL_HIGH: amp_sel_out <= AMP_PLUS5;
          LVL_RES: amp_sel_out <= AMP_PLUS10;
          LVL_LOW: amp_sel_out <= AMP_MINUS5;
          default: amp_sel_out <= AMP_NOMINAL;
        endcase
      end
      // R11 R12 emphasis off unless manual
      preemph_en_out <= preemph_manual_in;
      preemph_amount_out <= preemph_amount_in;
      // R13 R14 edge rate by rate or host
      if (reclock_bypass_out) begin
        edge_slow_out <= edge_slow_manual_in;
      end else begin
        edge_slow_out <= (detected_rate_in == RATE_SD);
      end
      // R15 independent polarity
      invert_bidir_out <= invert_bidir_in;
      invert_second_out <= invert_second_in;
    end
  end

  // R1 R2 eye sweep sequencer
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      eye_state <= EYE_IDLE;
      ph <= '0;
      vo <= '0;
      eye_volt_mv_out <= SPAN_RESET;
    end else begin
      case (eye_state)
        EYE_IDLE: begin
          if (eye_start_in && top_rate) begin
            eye_state <= EYE_SWEEP;
            ph <= '0;
            vo <= '0;
            eye_volt_mv_out <= clamp_span(eye_span_mv_in);
          end
        end
        EYE_SWEEP: begin
          if (!top_rate) begin
            eye_state <= EYE_IDLE;
          end else begin
            ph <= ph + 6'h01;
            if (ph == 6'h3F) begin
              vo <= vo + 6'h01;
              if (vo == 6'h3F) begin
                eye_state <= EYE_REDUCE;
              end
            end
          end
        end
        EYE_REDUCE: begin
          ph <= ph + 6'h01;
          if (ph == 6'h3F) begin
            eye_state <= top_rate ? EYE_DONE : EYE_IDLE;
          end
        end
        EYE_DONE: begin
          if (eye_start_in && top_rate) begin
            eye_state <= EYE_SWEEP;
            ph <= '0;
            vo <= '0;
            eye_volt_mv_out <= clamp_span(eye_span_mv_in);
          end else if (!top_rate) begin
            eye_state <= EYE_IDLE;
          end
        end
        default: eye_state <= EYE_IDLE;
      endcase
    end
  end

  assign eye_phase_out = ph;
  assign eye_volt_out = vo;
  assign eye_busy_out = (eye_state == EYE_SWEEP) || (eye_state == EYE_REDUCE);
  // R1 results shown only at top rate
  assign eye_valid_out = (eye_state == EYE_DONE) && top_rate;

  // R3 per-point hit flag store, one sample per point
  always_ff @(posedge clk_in) begin
    if (eye_state == EYE_SWEEP && top_rate) begin
      hits[grid_addr(vo, ph)] <= {{(HIT_W-1){1'b0}}, eye_hit_in};
    end
    hit_rd_data_out <= hits[hit_rd_addr_in];
  end

  // R4 width on middle row, height on middle column
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      width_cnt <= '0;
      height_cnt <= '0;
      horizontal_eye_width_out <= '0;
      vertical_eye_height_out <= '0;
    end else if (eye_state == EYE_SWEEP && top_rate) begin
      if (vo == 6'h00 && ph == 6'h00) begin
        width_cnt <= '0;
        height_cnt <= '0;
      end else begin
        if (vo == MID_INDEX && !eye_hit_in) begin
          width_cnt <= width_cnt + 7'h01;
        end
        if (ph == MID_INDEX && !eye_hit_in) begin
          height_cnt <= height_cnt + 7'h01;
        end
      end
    end else if (eye_state == EYE_REDUCE && ph == 6'h3F) begin
      horizontal_eye_width_out <= width_cnt;
      vertical_eye_height_out <= height_cnt;
    end
  end

  // Assertions
  // Sweep steps: a start taken from idle, and a sweep that loses its rate
  sequence s_sweep_accept;
    eye_state == EYE_IDLE && eye_start_in && top_rate;
  endsequence
  sequence s_sweep_rate_lost;
    eye_state == EYE_SWEEP && !top_rate;
  endsequence
  // R1 results gated by rate
  chk_eye_rate_gate: assert property (@(posedge clk_in) disable iff (srst_in) // R1
    eye_valid_out |-> detected_rate_in == RATE_3G) else $error("eye result at low rate");
  // R1 sweep aborts at low rate
  chk_sweep_abort: assert property (@(posedge clk_in) disable iff (srst_in) // R1
    s_sweep_rate_lost |=> eye_state == EYE_IDLE && !eye_busy_out) else $error("sweep kept running at low rate");
  // R2 span clamped at start
  chk_span_clamp: assert property (@(posedge clk_in) disable iff (srst_in) // R2
    s_sweep_accept |=> eye_busy_out && eye_volt_mv_out <= SPAN_RESET && eye_phase_out == 6'h00)
    else $error("span not clamped");
  // R9 float gives nominal
  chk_amp_float_nominal: assert property (@(posedge clk_in) disable iff (srst_in) // R9
    (!amp_ovr_en_in && amp_s2 == LVL_FLOAT) |=> amp_sel_out == AMP_NOMINAL) else $error("float not nominal");
  // R5 resistor bypasses both
  chk_eq_res_bypass: assert property (@(posedge clk_in) disable iff (srst_in) // R5
    (!bypass_ovr_en_in && !drv && byp_lvl == LVL_RES) |=> eq_bypass_out && reclock_bypass_out)
    else $error("res level not bypassing both");
  // R6 driver low manual
  chk_drv_low_manual: assert property (@(posedge clk_in) disable iff (srst_in) // R6
    (!bypass_ovr_en_in && drv && byp_lvl == LVL_LOW) |=> manual_adapt_setting_out && !eq_bypass_out)
    else $error("driver low not manual");
  // R7 override wins decode
  chk_override_wins: assert property (@(posedge clk_in) disable iff (srst_in) // R7
    bypass_ovr_en_in |=> reclock_bypass_out == $past(reclock_bypass_ovr_in)) else $error("override ignored");
  // R8 line outputs drive
  chk_bidir_drive: assert property (@(posedge clk_in) disable iff (srst_in) // R8
    ##1 line_bidir_port_drive_out == $past(drv) && line_second_output_drive_out) else $error("drive wrong");
  // R12 manual emphasis applied
  chk_preemph_manual: assert property (@(posedge clk_in) disable iff (srst_in) // R12
    preemph_manual_in |=> preemph_en_out) else $error("manual emphasis ignored");
  // R13 standard rate slow
  chk_edge_sd_slow: assert property (@(posedge clk_in) disable iff (srst_in) // R13
    (!reclock_bypass_out && detected_rate_in == RATE_SD) |=> edge_slow_out) else $error("sd not slow");
  // R15 polarity on second output
  chk_polarity_split: assert property (@(posedge clk_in) disable iff (srst_in) // R15
    ##1 invert_second_out == $past(invert_second_in)) else $error("polarity not applied");
endmodule : path_cfg_eye
